// File: lptm_pkg.sv
/*
  constants, field layouts and types shared by the load protection
  trip monitor and its delay timer.
  assumes a 125 MHz ref_clk and a 32-bit plain register port.
*/
package lptm_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ          = 125_000_000;
  localparam int TICK_S          = 1;
  localparam int TICK_CYCLES_DEF = CLK_HZ * TICK_S;

  // ----------------------------------------------------------------
  // setting limits and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RATED_PCT     = 8'h64;
  localparam logic [6:0] THR_MAX       = 7'h63;
  localparam logic [6:0] DLY_MIN       = 7'h01;
  localparam logic [6:0] DLY_MAX       = 7'h63;
  localparam logic [6:0] THR_RST       = 7'h1e;
  localparam logic [6:0] DLY_RST       = 7'h01;
  localparam logic       BYP_EN_RST    = 1'h1;
  localparam logic [15:0] RATED_PWR_RST = 16'h0064;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_LOW_TORQUE  = 8'h00;
  localparam logic [7:0] OFF_HIGH_TORQUE = 8'h04;
  localparam logic [7:0] OFF_LOW_POWER   = 8'h08;
  localparam logic [7:0] OFF_HIGH_POWER  = 8'h0c;
  localparam logic [7:0] OFF_MISC        = 8'h10;
  localparam logic [7:0] OFF_RATED_POWER = 8'h14;
  localparam logic [7:0] OFF_STATUS      = 8'h18;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int FLD_MODE_LSB   = 0;
  localparam int FLD_THR_LSB    = 8;
  localparam int FLD_DLY_LSB    = 16;
  localparam int FLD_PHASE_LSB  = 0;
  localparam int FLD_BYP_EN_BIT = 4;

  // protection index; status holds fault at 2*i, alarm at 2*i+1
  localparam int PROT_N          = 4;
  localparam int ST_PH_RST_FAULT = 8;
  localparam int ST_PH_RTS_FAULT = 9;
  localparam int ST_BYP_FAULT    = 10;
  localparam int STATUS_W        = 11;
  localparam logic [10:0] FAULT_MASK = 11'h755;
  localparam logic [10:0] ALARM_MASK = 11'h0aa;

  typedef enum logic [1:0] {
    MODE_OFF,
    MODE_FAULT,
    MODE_ALARM
  } lptm_mode_type;

  typedef enum logic [1:0] {
    PHASE_NONE,
    PHASE_RST,
    PHASE_RTS
  } lptm_phase_type;

  typedef struct packed {
    lptm_mode_type mode;
    logic [6:0]    thr;
    logic [6:0]    dly;
  } lptm_prot_cfg_type;

endpackage

// File: lptm_delay_timer.sv
/*
  delay timer for one protection: counts whole seconds of an
  uninterrupted violation and flags expiry.
  assumes cond and dly come from logic on ref_clk.
*/
`timescale 1ns/1ps
module lptm_delay_timer
  import lptm_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       cond,
  input  wire logic [6:0] dly,
  output logic            expired
);

  localparam int CW = $clog2(TICK_CYCLES + 1);
  localparam logic [CW-1:0] CYC_LAST = CW'(TICK_CYCLES - 1);

  typedef struct packed {
    logic [CW-1:0] cyc;
    logic [6:0]    sec;
  } lptm_timer_state_type;

  lptm_timer_state_type state_r;
  lptm_timer_state_type state_nxt;

  // ----------------------------------------------------------------
  // counting
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    if (!cond) begin
      state_nxt = '0;
    end else if (state_r.sec < dly) begin
      if (state_r.cyc == CYC_LAST) begin
        state_nxt.cyc = '0;
        state_nxt.sec = state_r.sec + 7'h01;
      end else begin
        state_nxt.cyc = state_r.cyc + 1'b1;
      end
    end
    if (rst) begin
      state_nxt = '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    state_r <= state_nxt;
  end

  // seconds saturate at dly so the count cannot wrap
  assign expired = cond && (state_r.sec >= dly);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_last_cycle;
    cond && state_r.cyc == CYC_LAST && state_r.sec < dly;
  endsequence

  property p_restart;
    !cond |=> state_r.sec == 7'h00 && state_r.cyc == '0;
  endproperty
  a_restart: assert property (p_restart)
    else $error("timer did not restart after violation cleared");

  property p_second_step;
    s_last_cycle ##1 cond |-> state_r.sec == $past(state_r.sec) + 7'h01;
  endproperty
  a_second_step: assert property (p_second_step)
    else $error("second count did not advance at end of second");

  property p_expiry_moment;
    $rose(expired) && $stable(dly) && $past(cond) |->
      $past(state_r.sec) + 7'h01 == dly;
  endproperty
  a_expiry_moment: assert property (p_expiry_moment)
    else $error("expiry did not follow the last whole second");

endmodule

// File: lptm_protection_monitor.sv
/*
  load protection trip monitor: torque and power under/over trips,
  phase order check at start and bypass undercurrent check.
  assumes the measurement unit and start/bypass sequencer run on
  ref_clk and hold their outputs valid every cycle.
*/
// Decided for this implementation: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps

// What this block does
// - low torque mode: 0 off, 1 fault disabling motor, 2 alarm; default 0.
// - low torque level 0..99 pct, default 30; delay 1..99 s, default 1.
// - torque below 100 minus threshold for the whole delay trips per mode.
// - high torque mode: 0 off, 1 fault, 2 alarm; default 0.
// - high torque level 0..99 pct, default 30; delay 1..99 s, default 1.
// - torque above 100 plus threshold for the whole delay trips per mode.
// - torque deviation is measured percentage against 100 percent rated.
// - torque and power checks run only at full voltage after start.
// - low power mode: 0 off, 1 fault, 2 alarm; default 0.
// - low power level 0..99 pct, default 30; delay 1..99 s, default 1.
// - high power mode: 0 off, 1 fault, 2 alarm; default 0.
// - high power level 0..99 pct, default 30; delay 1..99 s, default 1.
// - power deviation is power minus rated, over rated, in percent.
// - power below rated minus threshold for the whole delay trips per mode.
// - power above rated plus threshold for the whole delay trips per mode.
// - with phase check enabled, phase order is checked at every start.
// - phase select 0 none, 1 only R-S-T, 2 only R-T-S; own fault each.
// - bypass low current check, default on: fault and block closing.
// - with bypass check off, low current motors may start and bypass.
module lptm_protection_monitor
  import lptm_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF,
  parameter int TORQUE_W    = 10,
  parameter int POWER_W     = 16
) (
  input  wire logic                ref_clk,
  input  wire logic                rst,
  input  wire logic [7:0]          regAddr,
  input  wire logic [31:0]         regWrData,
  input  wire logic                regWrEn,
  input  wire logic                regRdEn,
  output logic      [31:0]         regRdData,
  input  wire logic                fullVoltage,
  input  wire logic [TORQUE_W-1:0] presentTorquePct,
  input  wire logic [POWER_W-1:0]  measuredActivePower,
  input  wire logic                motorStart,
  input  wire logic                phaseIsRts,
  input  wire logic                bypassCloseReq,
  input  wire logic                currentBelowMin,
  input  wire logic                supplyFault,
  input  wire logic                thyristorFault,
  output logic                     bypassCloseGrant,
  output logic                     motorDisable,
  output logic                     alarmActive,
  output logic      [STATUS_W-1:0] statusFlags
);

  localparam int PW = POWER_W + 8;

  typedef struct packed {
    lptm_prot_cfg_type [PROT_N-1:0] prot;
    lptm_phase_type                 phaseSel;
    logic                           bypEn;
    logic [POWER_W-1:0]             ratedPower;
    logic [STATUS_W-1:0]            status;
    logic [31:0]                    rdata;
    logic                           grant;
  } lptm_state_type;

  lptm_state_type state_r;
  lptm_state_type state_nxt;
  logic [PROT_N-1:0] violate;
  logic [PROT_N-1:0] cond;
  logic [PROT_N-1:0] expired;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // out-of-range writes are pulled into the legal setting range
  function automatic lptm_prot_cfg_type clampCfg(input logic [31:0] d);
    lptm_prot_cfg_type c;
    logic [1:0] m;
    logic [6:0] t;
    logic [6:0] y;
    m = d[FLD_MODE_LSB +: 2];
    t = d[FLD_THR_LSB +: 7];
    y = d[FLD_DLY_LSB +: 7];
    c.mode = (m > 2'h2) ? MODE_OFF : lptm_mode_type'(m);
    c.thr  = (t > THR_MAX) ? THR_MAX : t;
    c.dly  = (y < DLY_MIN) ? DLY_MIN : ((y > DLY_MAX) ? DLY_MAX : y);
    return c;
  endfunction

  function automatic logic [31:0] packCfg(input lptm_prot_cfg_type c);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[FLD_MODE_LSB +: 2] = c.mode;
    w[FLD_THR_LSB +: 7]  = c.thr;
    w[FLD_DLY_LSB +: 7]  = c.dly;
    return w;
  endfunction

  // value times a percentage; compares replace a divider
  function automatic logic [PW-1:0] scalePct(input logic [POWER_W-1:0] v,
                                             input logic [7:0] pct);
    return PW'(v) * PW'(pct);
  endfunction

  function automatic lptm_state_type stateRst();
    lptm_state_type r;
    r = '0;
    for (int i = 0; i < PROT_N; i++) begin
      r.prot[i].mode = MODE_OFF;
      r.prot[i].thr  = THR_RST;
      r.prot[i].dly  = DLY_RST;
    end
    r.phaseSel   = PHASE_NONE;
    r.bypEn      = BYP_EN_RST;
    r.ratedPower = POWER_W'(RATED_PWR_RST);
    return r;
  endfunction

  // ----------------------------------------------------------------
  // deviation compares
  // ----------------------------------------------------------------
  always_comb begin
    logic [TORQUE_W:0] tq;
    logic [PW-1:0]     pScaled;
    tq = {1'b0, presentTorquePct};
    pScaled = scalePct(measuredActivePower, RATED_PCT);
    // torque percent against 100 plus or minus the threshold
    violate[0] = tq < (TORQUE_W+1)'(RATED_PCT - {1'b0, state_r.prot[0].thr});
    violate[1] = tq > (TORQUE_W+1)'(RATED_PCT + {1'b0, state_r.prot[1].thr});
    // 100*P against rated*(100 -/+ thr)
    violate[2] = pScaled < scalePct(state_r.ratedPower,
                                    RATED_PCT - {1'b0, state_r.prot[2].thr});
    violate[3] = pScaled > scalePct(state_r.ratedPower,
                                    RATED_PCT + {1'b0, state_r.prot[3].thr});
    for (int i = 0; i < PROT_N; i++) begin
      // ignored while starting
      cond[i] = fullVoltage && (state_r.prot[i].mode != MODE_OFF)
                && violate[i];
    end
  end

  // ----------------------------------------------------------------
  // delay timers
  // ----------------------------------------------------------------
  for (genvar g = 0; g < PROT_N; g++) begin : gTimer
    lptm_delay_timer #(
      .TICK_CYCLES (TICK_CYCLES)
    ) uTimer (
      .ref_clk (ref_clk),
      .rst     (rst),
      .cond    (cond[g]),
      .dly     (state_r.prot[g].dly),
      .expired (expired[g])
    );
  end

  // ----------------------------------------------------------------
  // registers and events
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    state_nxt.rdata = 32'h0000_0000;
    state_nxt.grant = 1'b0;
    if (regWrEn) begin
      case (regAddr)
        OFF_LOW_TORQUE:  state_nxt.prot[0] = clampCfg(regWrData);
        OFF_HIGH_TORQUE: state_nxt.prot[1] = clampCfg(regWrData);
        OFF_LOW_POWER:   state_nxt.prot[2] = clampCfg(regWrData);
        OFF_HIGH_POWER:  state_nxt.prot[3] = clampCfg(regWrData);
        OFF_MISC: begin
          state_nxt.phaseSel =
            (regWrData[FLD_PHASE_LSB +: 2] > 2'h2) ? PHASE_NONE :
            lptm_phase_type'(regWrData[FLD_PHASE_LSB +: 2]);
          state_nxt.bypEn = regWrData[FLD_BYP_EN_BIT];
        end
        OFF_RATED_POWER: state_nxt.ratedPower = regWrData[POWER_W-1:0];
        // write one to clear; events below are applied after, so set wins
        OFF_STATUS: state_nxt.status = state_r.status
                                       & ~regWrData[STATUS_W-1:0];
        default: ;
      endcase
    end
    if (regRdEn) begin
      case (regAddr)
        OFF_LOW_TORQUE:  state_nxt.rdata = packCfg(state_r.prot[0]);
        OFF_HIGH_TORQUE: state_nxt.rdata = packCfg(state_r.prot[1]);
        OFF_LOW_POWER:   state_nxt.rdata = packCfg(state_r.prot[2]);
        OFF_HIGH_POWER:  state_nxt.rdata = packCfg(state_r.prot[3]);
        OFF_MISC: begin
          state_nxt.rdata[FLD_PHASE_LSB +: 2] = state_r.phaseSel;
          state_nxt.rdata[FLD_BYP_EN_BIT]     = state_r.bypEn;
        end
        OFF_RATED_POWER: state_nxt.rdata[POWER_W-1:0] = state_r.ratedPower;
        OFF_STATUS:      state_nxt.rdata[STATUS_W-1:0] = state_r.status;
        default: ;
      endcase
    end
    for (int i = 0; i < PROT_N; i++) begin
      if (expired[i]) begin
        if (state_r.prot[i].mode == MODE_FAULT) begin
          state_nxt.status[2*i] = 1'b1;
        end else if (state_r.prot[i].mode == MODE_ALARM) begin
          state_nxt.status[2*i+1] = 1'b1;
        end
      end
    end
    if (motorStart) begin
      if (state_r.phaseSel == PHASE_RST && phaseIsRts) begin
        state_nxt.status[ST_PH_RST_FAULT] = 1'b1;
      end
      if (state_r.phaseSel == PHASE_RTS && !phaseIsRts) begin
        state_nxt.status[ST_PH_RTS_FAULT] = 1'b1;
      end
    end
    if (bypassCloseReq) begin
      if (state_r.bypEn && (currentBelowMin || supplyFault
                            || thyristorFault)) begin
        state_nxt.status[ST_BYP_FAULT] = 1'b1;
      end else begin
        state_nxt.grant = 1'b1;
      end
    end
    if (rst) begin
      state_nxt = stateRst();
    end
  end

  always_ff @(posedge ref_clk) begin
    state_r <= state_nxt;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign regRdData        = state_r.rdata;
  assign bypassCloseGrant = state_r.grant;
  assign statusFlags      = state_r.status;
  // faults stay until software clears them, so the motor stays off
  assign motorDisable     = |(state_r.status & FAULT_MASK);
  assign alarmActive      = |(state_r.status & ALARM_MASK);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  property p_reset_defaults;
    $past(rst) |-> state_r.prot[0].mode == MODE_OFF
      && state_r.prot[0].thr == THR_RST && state_r.prot[0].dly == DLY_RST
      && state_r.bypEn == BYP_EN_RST && state_r.phaseSel == PHASE_NONE;
  endproperty
  a_reset_defaults: assert property (p_reset_defaults)
    else $error("settings not at defaults after reset");

  property p_fault_trip;
    expired[0] && state_r.prot[0].mode == MODE_FAULT |=>
      statusFlags[0] && motorDisable;
  endproperty
  a_fault_trip: assert property (p_fault_trip)
    else $error("low torque expiry did not raise a disabling fault");

  property p_alarm_only;
    expired[1] && state_r.prot[1].mode == MODE_ALARM && !statusFlags[2]
      && !(regWrEn && regAddr == OFF_STATUS) |=>
      statusFlags[3] && !statusFlags[2];
  endproperty
  a_alarm_only: assert property (p_alarm_only)
    else $error("high torque alarm mode raised a fault or no alarm");

  property p_start_ignored;
    !fullVoltage |-> cond == '0 && expired == '0;
  endproperty
  a_start_ignored: assert property (p_start_ignored)
    else $error("protection active outside full voltage");

  property p_torque_compare;
    fullVoltage && state_r.prot[0].mode != MODE_OFF &&
      {1'b0, presentTorquePct} + state_r.prot[0].thr < RATED_PCT
      |-> cond[0];
  endproperty
  a_torque_compare: assert property (p_torque_compare)
    else $error("low torque deviation not detected");

  property p_power_compare;
    fullVoltage && state_r.prot[3].mode != MODE_OFF &&
      scalePct(measuredActivePower, RATED_PCT) >
      scalePct(state_r.ratedPower, RATED_PCT + {1'b0, state_r.prot[3].thr})
      |-> cond[3];
  endproperty
  a_power_compare: assert property (p_power_compare)
    else $error("high power deviation not detected");

  sequence s_bad_close;
    bypassCloseReq && state_r.bypEn && currentBelowMin;
  endsequence

  property p_bypass_block;
    s_bad_close |=> !bypassCloseGrant && statusFlags[ST_BYP_FAULT];
  endproperty
  a_bypass_block: assert property (p_bypass_block)
    else $error("bypass closed on low current with check enabled");

  property p_bypass_free;
    bypassCloseReq && !state_r.bypEn |=> bypassCloseGrant;
  endproperty
  a_bypass_free: assert property (p_bypass_free)
    else $error("bypass refused with check disabled");

  property p_phase_check;
    motorStart && state_r.phaseSel == PHASE_RTS && !phaseIsRts |=>
      statusFlags[ST_PH_RTS_FAULT] && motorDisable;
  endproperty
  a_phase_check: assert property (p_phase_check)
    else $error("wrong phase order at start not faulted");

  property p_read_slot;
    !$past(regRdEn) |-> regRdData == 32'h0000_0000;
  endproperty
  a_read_slot: assert property (p_read_slot)
    else $error("read data outside its slot");

endmodule

// File: lptm_far_side.sv
/*
  far side model: measurement unit and start/bypass sequencer.
  assumes ref_clk is the monitor's clock; the bench calls the tasks.
*/
`timescale 1ns/1ps
module lptm_far_side (
  input  wire logic   ref_clk,
  output logic        fullVoltage,
  output logic [9:0]  presentTorquePct,
  output logic [15:0] measuredActivePower,
  output logic        motorStart,
  output logic        phaseIsRts,
  output logic        bypassCloseReq,
  output logic        currentBelowMin,
  output logic        supplyFault,
  output logic        thyristorFault
);
  initial begin
    fullVoltage = 1'h0;
    presentTorquePct = 10'h064;
    measuredActivePower = 16'h0064;
    motorStart = 1'h0;
    phaseIsRts = 1'h0;
    bypassCloseReq = 1'h0;
    currentBelowMin = 1'h0;
    supplyFault = 1'h0;
    thyristorFault = 1'h0;
  end

  // ----------------------------------------------------------------
  // levels and pulses, changed just after an edge
  // ----------------------------------------------------------------
  task automatic set_load(input logic fv, input int trq, input int pwr);
    @(posedge ref_clk);
    fullVoltage <= fv;
    presentTorquePct <= 10'(trq);
    measuredActivePower <= 16'(pwr);
  endtask

  task automatic start_pulse(input logic rts);
    @(posedge ref_clk);
    motorStart <= 1'h1;
    phaseIsRts <= rts;
    @(posedge ref_clk);
    motorStart <= 1'h0;
    // order means nothing outside the start pulse, so do not hold it
    phaseIsRts <= ~rts;
  endtask

  task automatic close_req(input logic low, input logic sup,
                           input logic thy);
    @(posedge ref_clk);
    bypassCloseReq <= 1'h1;
    currentBelowMin <= low;
    supplyFault <= sup;
    thyristorFault <= thy;
    @(posedge ref_clk);
    bypassCloseReq <= 1'h0;
    currentBelowMin <= ~low;
    supplyFault <= ~sup;
    thyristorFault <= ~thy;
  endtask
endmodule

// File: lptm_protection_monitor_tb.sv
/*
  self-checking bench for the load protection trip monitor.
  assumes lptm_pkg and the far side model are compiled first.
*/
`timescale 1ns/1ps
module lptm_protection_monitor_tb
  import lptm_pkg::*;
();
  localparam int TICK  = 4;
  localparam int LIMIT = 6000;
  logic                ref_clk = 1'h0;
  logic                rst = 1'h1;
  logic [7:0]          regAddr;
  logic [31:0]         regWrData;
  logic                regWrEn;
  logic                regRdEn;
  logic [31:0]         regRdData;
  logic                fullVoltage;
  logic [9:0]          presentTorquePct;
  logic [15:0]         measuredActivePower;
  logic                motorStart;
  logic                phaseIsRts;
  logic                bypassCloseReq;
  logic                currentBelowMin;
  logic                supplyFault;
  logic                thyristorFault;
  logic                bypassCloseGrant;
  logic                motorDisable;
  logic                alarmActive;
  logic [STATUS_W-1:0] statusFlags;
  logic [31:0]         seed = 32'h0000_003d;
  int                  n_errors = 0;
  int                  comparisons = 0;
  int                  cycles = 0;
  int                  rated = 200;

  always #4 ref_clk = ~ref_clk;

  lptm_protection_monitor #(.TICK_CYCLES(TICK)) DUT (
    .ref_clk(ref_clk), .rst(rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regRdData(regRdData), .fullVoltage(fullVoltage),
    .presentTorquePct(presentTorquePct),
    .measuredActivePower(measuredActivePower), .motorStart(motorStart),
    .phaseIsRts(phaseIsRts), .bypassCloseReq(bypassCloseReq),
    .currentBelowMin(currentBelowMin), .supplyFault(supplyFault),
    .thyristorFault(thyristorFault), .bypassCloseGrant(bypassCloseGrant),
    .motorDisable(motorDisable), .alarmActive(alarmActive),
    .statusFlags(statusFlags));

  lptm_far_side far (
    .ref_clk(ref_clk), .fullVoltage(fullVoltage),
    .presentTorquePct(presentTorquePct),
    .measuredActivePower(measuredActivePower), .motorStart(motorStart),
    .phaseIsRts(phaseIsRts), .bypassCloseReq(bypassCloseReq),
    .currentBelowMin(currentBelowMin), .supplyFault(supplyFault),
    .thyristorFault(thyristorFault));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic int rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return int'(seed[15:0]);
  endfunction

  task automatic test_done();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t reg got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_out(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t out got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    regWrEn <= 1'h1;
    regAddr <= a;
    regWrData <= d;
    @(posedge ref_clk);
    regWrEn <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    regRdEn <= 1'h1;
    regAddr <= a;
    @(posedge ref_clk);
    regRdEn <= 1'h0;
    #1 chk_reg(regRdData, exp);
  endtask

  // how: 0 held, 1 broken once, 2 exactly at level, 3 not at full voltage
  task automatic prot(input int k, input int mode, input int how);
    int thr, dly, val, cyc, viol, pwr;
    logic [15:0] st;
    thr = rnd() % 100;
    dly = 1 + rnd() % 2;
    cyc = dly * TICK;
    val = (k % 2 == 0) ? 99 - thr + (how == 2) : 101 + thr - (how == 2);
    pwr = val * rated / 100;
    case (k)
      0: viol = val < 100 - thr;
      1: viol = val > 100 + thr;
      2: viol = 100 * pwr < rated * (100 - thr);
      default: viol = 100 * pwr > rated * (100 + thr);
    endcase
    viol = viol && how != 3 && how != 1 && mode != 0;
    st = viol ? 16'(1) << (2 * k + (mode == 2)) : 16'h0000;
    wr(8'(4 * k), 32'(dly << 16 | thr << 8 | mode));
    far.set_load(how != 3, k < 2 ? val : 100, k < 2 ? rated : pwr);
    if (how == 1) begin
      repeat (cyc - 3) @(posedge ref_clk);
      far.set_load(1'h1, 100, rated);
      far.set_load(1'h1, k < 2 ? val : 100, k < 2 ? rated : pwr);
    end
    repeat (how == 1 ? cyc - 3 : cyc + 3) @(posedge ref_clk);
    far.set_load(1'h1, 100, rated);
    rd(OFF_STATUS, 32'(st));
    chk_out(16'(statusFlags), st);
    chk_out(16'(motorDisable), 16'(viol && mode == 1));
    chk_out(16'(alarmActive), 16'(viol && mode == 2));
    wr(OFF_STATUS, 32'h0000_07ff);
    rd(OFF_STATUS, 32'h0000_0000);
    wr(8'(4 * k), 32'h0001_1e00);
  endtask

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      n_errors++;
      test_done();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [15:0] exp;
    logic        flt;
    regAddr = 8'h00;
    regWrData = 32'h0000_0000;
    regWrEn = 1'h0;
    regRdEn = 1'h0;
    repeat (4) @(posedge ref_clk);
    rst <= 1'h0;
    #1 chk_out(16'(statusFlags), 16'h0000);
    chk_out(16'(motorDisable | alarmActive), 16'h0000);
    chk_out(16'(bypassCloseGrant), 16'h0000);
    for (int k = 0; k < 4; k++) begin
      rd(8'(4 * k), 32'h0001_1e00);
    end
    rd(OFF_MISC, 32'h0000_0010);
    rd(OFF_RATED_POWER, 32'h0000_0064);
    rd(OFF_STATUS, 32'h0000_0000);
    rd(8'h1c, 32'h0000_0000);
    wr(OFF_LOW_TORQUE, 32'h0000_7f03);
    rd(OFF_LOW_TORQUE, 32'h0001_6300);
    wr(OFF_HIGH_TORQUE, 32'h007f_6303);
    rd(OFF_HIGH_TORQUE, 32'h0063_6300);
    wr(OFF_LOW_TORQUE, 32'h0001_1e00);
    wr(OFF_HIGH_TORQUE, 32'h0001_1e00);
    wr(OFF_RATED_POWER, 32'(rated));
    far.set_load(1'h1, 100, rated);
    for (int k = 0; k < 4; k++) begin
      for (int m = 0; m < 3; m++) begin
        prot(k, m, 0);
      end
      for (int h = 1; h < 4; h++) begin
        prot(k, 1, h);
      end
    end
    for (int s = 0; s < 4; s++) begin
      for (int r = 0; r < 2; r++) begin
        wr(OFF_MISC, 32'(16 | s));
        far.start_pulse(r[0]);
        repeat (2) @(posedge ref_clk);
        exp = (s == 1 && r == 1) ? 16'h0100 :
              (s == 2 && r == 0) ? 16'h0200 : 16'h0000;
        #1 chk_out(16'(statusFlags), exp);
        chk_out(16'(motorDisable), 16'(exp != 0));
        wr(OFF_STATUS, 32'h0000_07ff);
      end
    end
    for (int en = 0; en < 2; en++) begin
      for (int f = 0; f < 8; f++) begin
        flt = en == 1 && f != 0;
        wr(OFF_MISC, 32'(en << 4));
        far.close_req(f[0], f[1], f[2]);
        #1 chk_out(16'(bypassCloseGrant), 16'(!flt));
        repeat (2) @(posedge ref_clk);
        #1 chk_out(16'(statusFlags), flt ? 16'h0400 : 16'h0000);
        chk_out(16'(motorDisable), 16'(flt));
        wr(OFF_STATUS, 32'h0000_07ff);
      end
    end
    test_done();
  end
endmodule
